/* hw/dasq_top.sv */
// disk address sequencer: sector, head, cylinder and memory pointer
// assumes strobes and error levels come from logic on MCLK;
// the drive position report arrives from the unit cable, unsynchronised
`include "dasq_defs.svh"
`default_nettype none

module dasq_top
  import dasq_pkg::*;
(
  input wire logic MCLK,                                // system clock
  input wire logic RESET_N,                             // async reset, active low
  input wire logic [0:`DASQ_BUS_W-1] IO_BUS_IN,         // host bus data, bit 0 msb
  input wire logic LOAD_DISK_ADDRESS_CMD,               // preset address counters
  input wire logic LOAD_MEMORY_POINTER_CMD,             // preset memory pointer
  input wire logic READ_DISK_ADDRESS_CMD,               // address readback
  input wire logic CONTROLLER_CLEAR,                    // clears all counters
  input wire logic SECTOR_COUNTER_CLEAR,                // clears sector only
  input wire logic HEAD_COUNTER_CLEAR,                  // clears head only
  input wire logic CYLINDER_COUNTER_CLEAR,              // clears cylinder only
  input wire logic MEMORY_POINTER_CLEAR,                // clears pointer only
  input wire logic SECTOR_END,                          // high over each sector end
  input wire logic MAINT_SECTOR_STEP,                   // one-cycle maintenance step
  input wire logic WORD_PARITY_ERROR,                   // word parity error seen
  input wire logic LONGITUDINAL_PARITY_ERROR,           // longitudinal parity error
  input wire logic COMPARE_MISMATCH_ERROR,              // write check mismatch
  input wire logic TIMING_ERROR,                        // data timing error
  input wire logic NORMAL_MODE,                         // high normal, low format
  input wire logic [2:0] FUNCTION_CODE,                 // current function
  input wire logic WORD_MOVED,                          // one-cycle host word done
  input wire logic [`DASQ_CYL_W-1:0] DRIVE_POSITION_REPORT, // drive cylinder
  output logic [`DASQ_SECTOR_W-1:0] SECTOR_ADDRESS,     // sector counter
  output logic [`DASQ_HEAD_W-1:0] HEAD_ADDRESS,         // head counter
  output logic [`DASQ_CYL_W-1:0] CYLINDER_ADDRESS,      // cylinder counter
  output logic [`DASQ_MP_W-1:0] MEMORY_POINTER,         // memory pointer counter
  output logic SECTOR_ILLEGAL,                          // sector code illegal
  output logic HEAD_ILLEGAL,                            // head code illegal
  output logic CYLINDER_ILLEGAL,                        // cylinder code illegal
  output logic SECTOR_WRAP_FLAG,                        // wrap pending to zero
  output logic PACK_LIMIT_REACHED,                      // pack_limit_reached, sticky
  output logic CYLINDER_MATCH,                          // counter equals drive
  output logic SEEK_NEEDED,                             // counter differs from drive
  output logic [0:`DASQ_BUS_W-1] BUS_OUT,               // readback data
  output logic SECTOR_WORDS_DONE                        // full sector moved
);

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_sync_q;
  logic rst_n;

  // two-stage release of the async reset
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************
  // counters
  // ****************************************
  dasq_cnt_if #(.W(`DASQ_SECTOR_W)) sec_if ();
  dasq_cnt_if #(.W(`DASQ_HEAD_W)) hd_if ();
  dasq_cnt_if #(.W(`DASQ_CYL_W)) cy_if ();
  dasq_cnt_if #(.W(`DASQ_MP_W)) mp_if ();

  dasq_counter #(.W(`DASQ_SECTOR_W), .MAX(`DASQ_SECTOR_MAX), .CHECK(1'b1)) u_sector (
    .clk(MCLK),
    .rst_n(rst_n),
    .c(sec_if.cnt)
  );

  dasq_counter #(.W(`DASQ_HEAD_W), .MAX(`DASQ_HEAD_MAX), .CHECK(1'b1)) u_head (
    .clk(MCLK),
    .rst_n(rst_n),
    .c(hd_if.cnt)
  );

  dasq_counter #(.W(`DASQ_CYL_W), .MAX(`DASQ_CYL_MAX), .CHECK(1'b1)) u_cyl (
    .clk(MCLK),
    .rst_n(rst_n),
    .c(cy_if.cnt)
  );

  dasq_counter #(.W(`DASQ_MP_W), .MAX(`DASQ_MP_MAX), .CHECK(1'b0)) u_mptr (
    .clk(MCLK),
    .rst_n(rst_n),
    .c(mp_if.cnt)
  );

  // ****************************************
  // event decode
  // ****************************************
  dasq_seq_state_type s_q;
  dasq_seq_state_type s_d;
  dasq_func_type func;
  logic lead;
  logic trail;
  logic fault;
  logic sec_ok;
  logic raw_fn;
  logic track_fn;
  logic head_step;
  logic cyl_step;
  logic pack_hit;
  logic sec_quiet;
  logic [`DASQ_CYL_W-1:0] bus_cyl;
  logic [`DASQ_HEAD_W-1:0] bus_head;
  logic [`DASQ_SECTOR_W-1:0] bus_sec;

  assign func = dasq_func_type'(FUNCTION_CODE);
  assign bus_cyl = IO_BUS_IN[`DASQ_BUS_CYL_MSB:`DASQ_BUS_CYL_LSB];
  assign bus_head = IO_BUS_IN[`DASQ_BUS_HEAD_MSB:`DASQ_BUS_HEAD_LSB];
  assign bus_sec = IO_BUS_IN[`DASQ_BUS_SEC_MSB:`DASQ_BUS_SEC_LSB];

  // edges of the sector end level
  assign lead = SECTOR_END && !s_q.se_prev;
  assign trail = !SECTOR_END && s_q.se_prev;

  assign fault = WORD_PARITY_ERROR || LONGITUDINAL_PARITY_ERROR ||
                 COMPARE_MISMATCH_ERROR || TIMING_ERROR;
  assign sec_ok = lead && NORMAL_MODE && !fault;

  assign raw_fn = (func == DASQ_FN_READ_ALL) || (func == DASQ_FN_WRITE_ALL);
  assign track_fn = (func == DASQ_FN_READ) || (func == DASQ_FN_WRITE) ||
                    (func == DASQ_FN_WRITE_CHECK);

  // no other sector action in this cycle
  assign sec_quiet = !MAINT_SECTOR_STEP && !LOAD_DISK_ADDRESS_CMD &&
                     !CONTROLLER_CLEAR && !SECTOR_COUNTER_CLEAR;

  // head carry on wrap; raw carry leaving sector eight
  assign head_step = sec_ok && ((track_fn && sec_if.at_max) ||
                     (raw_fn && (sec_if.value == `DASQ_SECTOR_RAW)));
  assign cyl_step = head_step && hd_if.at_max;
  assign pack_hit = cyl_step && cy_if.at_max;

  // ****************************************
  // counter control
  // ****************************************
  // sector end or maintenance advances, blocked at nine
  assign sec_if.step = (sec_ok || MAINT_SECTOR_STEP) && !sec_if.at_max;
  // clear on trailing edge when wrap pending
  assign sec_if.clr = CONTROLLER_CLEAR || SECTOR_COUNTER_CLEAR ||
                      (trail && s_q.wrap) || (MAINT_SECTOR_STEP && sec_if.at_max);
  assign sec_if.load = LOAD_DISK_ADDRESS_CMD;
  assign sec_if.load_val = bus_sec;

  assign hd_if.step = head_step && !hd_if.at_max;
  assign hd_if.clr = CONTROLLER_CLEAR || HEAD_COUNTER_CLEAR || cyl_step;
  assign hd_if.load = LOAD_DISK_ADDRESS_CMD;
  assign hd_if.load_val = bus_head;

  assign cy_if.step = cyl_step && !cy_if.at_max;
  assign cy_if.clr = CONTROLLER_CLEAR || CYLINDER_COUNTER_CLEAR || pack_hit;
  assign cy_if.load = LOAD_DISK_ADDRESS_CMD;
  assign cy_if.load_val = bus_cyl;

  assign mp_if.load = LOAD_MEMORY_POINTER_CMD;
  assign mp_if.load_val = IO_BUS_IN;
  assign mp_if.clr = MEMORY_POINTER_CLEAR || CONTROLLER_CLEAR;
  assign mp_if.step = WORD_MOVED;

  // ****************************************
  // sequencer state
  // ****************************************
  // next state of flags, synchroniser, readback and word tally
  always_comb begin
    s_d = s_q;
    s_d.pos_meta = DRIVE_POSITION_REPORT;
    s_d.pos_sync = s_q.pos_meta;
    s_d.se_prev = SECTOR_END;
    // arm wrap at leading edge, set wins
    if (sec_ok && sec_if.at_max) begin
      s_d.wrap = 1'b1;
    end else if (trail || LOAD_DISK_ADDRESS_CMD || CONTROLLER_CLEAR) begin
      s_d.wrap = 1'b0;
    end
    if (pack_hit) begin
      s_d.pack = 1'b1;
    end else if (LOAD_DISK_ADDRESS_CMD || CONTROLLER_CLEAR) begin
      s_d.pack = 1'b0;
    end
    s_d.match = (cy_if.value == s_q.pos_sync);
    s_d.seek = (cy_if.value != s_q.pos_sync);
    if (READ_DISK_ADDRESS_CMD) begin
      s_d.bus_out = {cy_if.value, hd_if.value, 1'b0, sec_if.value};
    end else begin
      s_d.bus_out = '0;
    end
    if (lead || CONTROLLER_CLEAR) begin
      s_d.host_words = 9'h000;
      s_d.sector_full = 1'b0;
    end else if (WORD_MOVED && !s_q.sector_full) begin
      s_d.host_words = s_q.host_words + 9'h001;
      s_d.sector_full = (s_d.host_words == `DASQ_SECTOR_HOST_WORDS);
    end
  end

  // state register
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign SECTOR_ADDRESS = sec_if.value;
  assign HEAD_ADDRESS = hd_if.value;
  assign CYLINDER_ADDRESS = cy_if.value;
  assign MEMORY_POINTER = mp_if.value;
  assign SECTOR_ILLEGAL = sec_if.illegal;
  assign HEAD_ILLEGAL = hd_if.illegal;
  assign CYLINDER_ILLEGAL = cy_if.illegal;
  assign SECTOR_WRAP_FLAG = s_q.wrap;
  assign PACK_LIMIT_REACHED = s_q.pack;
  assign CYLINDER_MATCH = s_q.match;
  assign SEEK_NEEDED = s_q.seek;
  assign BUS_OUT = s_q.bus_out;
  assign SECTOR_WORDS_DONE = s_q.sector_full;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!rst_n);

  property p_sector_flag;
    SECTOR_ILLEGAL == (SECTOR_ADDRESS > `DASQ_SECTOR_MAX);
  endproperty
  a_sector_flag: assert property (p_sector_flag)
    else $error("sector illegal flag wrong");

  property p_head_flag;
    HEAD_ILLEGAL == (HEAD_ADDRESS > `DASQ_HEAD_MAX);
  endproperty
  a_head_flag: assert property (p_head_flag)
    else $error("head illegal flag wrong");

  property p_cyl_flag;
    CYLINDER_ILLEGAL == (CYLINDER_ADDRESS > `DASQ_CYL_MAX);
  endproperty
  a_cyl_flag: assert property (p_cyl_flag)
    else $error("cylinder illegal flag wrong");

  property p_load_addr;
    LOAD_DISK_ADDRESS_CMD |=> CYLINDER_ADDRESS == $past(bus_cyl) &&
      HEAD_ADDRESS == $past(bus_head) && SECTOR_ADDRESS == $past(bus_sec);
  endproperty
  a_load_addr: assert property (p_load_addr)
    else $error("address load did not take bus bits");

  property p_fault_hold;
    lead && fault && sec_quiet |=> $stable(SECTOR_ADDRESS);
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("sector advanced despite error");

  property p_format_hold;
    lead && !NORMAL_MODE && sec_quiet |=> $stable(SECTOR_ADDRESS);
  endproperty
  a_format_hold: assert property (p_format_hold)
    else $error("sector advanced in format mode");

  sequence s_wrap_arm;
    sec_ok && sec_if.at_max && sec_quiet;
  endsequence
  sequence s_wrap_held;
    SECTOR_WRAP_FLAG && SECTOR_ADDRESS == `DASQ_SECTOR_MAX;
  endsequence
  property p_wrap_arm;
    s_wrap_arm |=> s_wrap_held;
  endproperty
  a_wrap_arm: assert property (p_wrap_arm)
    else $error("sector nine did not hold for wrap");

  property p_wrap_clear;
    trail && SECTOR_WRAP_FLAG && !LOAD_DISK_ADDRESS_CMD |=>
      SECTOR_ADDRESS == 4'h0 && !SECTOR_WRAP_FLAG;
  endproperty
  a_wrap_clear: assert property (p_wrap_clear)
    else $error("sector did not wrap to zero");

  property p_head_carry;
    sec_ok && track_fn && sec_if.at_max && !hd_if.at_max && !LOAD_DISK_ADDRESS_CMD &&
      !CONTROLLER_CLEAR && !HEAD_COUNTER_CLEAR |=>
      HEAD_ADDRESS == $past(HEAD_ADDRESS) + 5'h01;
  endproperty
  a_head_carry: assert property (p_head_carry)
    else $error("head did not step on sector wrap");

  property p_pack_end;
    pack_hit && !LOAD_DISK_ADDRESS_CMD |=> PACK_LIMIT_REACHED && CYLINDER_ADDRESS == 8'h00;
  endproperty
  a_pack_end: assert property (p_pack_end)
    else $error("pack_limit_reached not handled");

  property p_seek_cmp;
    ($stable(CYLINDER_ADDRESS) && $stable(DRIVE_POSITION_REPORT)) [*3] |=>
      CYLINDER_MATCH == ($past(CYLINDER_ADDRESS) == $past(DRIVE_POSITION_REPORT)) &&
      SEEK_NEEDED == !CYLINDER_MATCH;
  endproperty
  a_seek_cmp: assert property (p_seek_cmp)
    else $error("cylinder compare wrong");

endmodule

`default_nettype wire

/* pkg/dasq_defs.svh */
// constants for the disk address sequencer: widths, limits, bus fields, sector layout
// assumes bus bit 0 is the most significant bit of every field
`ifndef DASQ_DEFS_SVH
`define DASQ_DEFS_SVH

// counter and host bus widths
`define DASQ_SECTOR_W 4
`define DASQ_HEAD_W 5
`define DASQ_CYL_W 8
`define DASQ_MP_W 18
`define DASQ_BUS_W 18

// highest legal counts, and the raw-function head carry sector
`define DASQ_SECTOR_MAX 4'h9
`define DASQ_SECTOR_RAW 4'h8
`define DASQ_HEAD_MAX 5'h13
`define DASQ_CYL_MAX 8'hCA
`define DASQ_MP_MAX 18'h3FFFF

// readback and load field positions on the host bus
`define DASQ_BUS_CYL_MSB 0
`define DASQ_BUS_CYL_LSB 7
`define DASQ_BUS_HEAD_MSB 8
`define DASQ_BUS_HEAD_LSB 12
`define DASQ_BUS_SEC_MSB 14
`define DASQ_BUS_SEC_LSB 17

// sector layout in host words
`define DASQ_DATA_WORDS 9'h080
`define DASQ_HEADER_WORDS 9'h001
`define DASQ_HOST_PER_WORD 9'h002
`define DASQ_SECTOR_HOST_WORDS \
  (9'((`DASQ_DATA_WORDS + `DASQ_HEADER_WORDS) * `DASQ_HOST_PER_WORD))

`endif

/* pkg/dasq_pkg.sv */
// types shared by the disk address sequencer modules
// assumes the constants header is on the include path
`include "dasq_defs.svh"
`default_nettype none

package dasq_pkg;

  // transfer function codes
  typedef enum logic [2:0] {
    DASQ_FN_IDLE = 3'h0,
    DASQ_FN_READ = 3'h1,
    DASQ_FN_WRITE = 3'h2,
    DASQ_FN_RECAL = 3'h3,
    DASQ_FN_SEEK = 3'h4,
    DASQ_FN_READ_ALL = 3'h5,
    DASQ_FN_WRITE_ALL = 3'h6,
    DASQ_FN_WRITE_CHECK = 3'h7
  } dasq_func_type;

  // sequencer state beyond the counters
  typedef struct packed {
    logic [`DASQ_CYL_W-1:0] pos_meta;
    logic [`DASQ_CYL_W-1:0] pos_sync;
    logic se_prev;
    logic wrap;
    logic pack;
    logic match;
    logic seek;
    logic [`DASQ_BUS_W-1:0] bus_out;
    logic [8:0] host_words;
    logic sector_full;
  } dasq_seq_state_type;

endpackage

`default_nettype wire

/* pkg/dasq_cnt_if.sv */
// control and status of one address counter
// assumes one controller and one counter per instance
`default_nettype none

interface dasq_cnt_if #(parameter int W = 4);
  logic clr;
  logic load;
  logic step;
  logic [W-1:0] load_val;
  logic [W-1:0] value;
  logic illegal;
  logic at_max;

  modport cnt (input clr, load, step, load_val, output value, illegal, at_max);
  modport ctl (output clr, load, step, load_val, input value, illegal, at_max);
endinterface

`default_nettype wire

/* hw/dasq_counter.sv */
// loadable up-counter with illegal-code decode
// assumes clear, load and step come from logic on the same clock
`default_nettype none

module dasq_counter #(
  parameter int W = 4,
  parameter logic [W-1:0] MAX = '1,
  parameter logic CHECK = 1'b1
) (
  input wire logic clk,    // system clock
  input wire logic rst_n,  // synchronised reset, active low
  dasq_cnt_if.cnt c        // control and status
);

  typedef struct packed {
    logic [W-1:0] value;
    logic illegal;
  } dasq_cnt_state_type;

  dasq_cnt_state_type s_q;
  dasq_cnt_state_type s_d;

  // ****************************************
  // next value
  // ****************************************
  // load presets the bits, otherwise clear, otherwise count
  always_comb begin
    s_d = s_q;
    if (c.load) begin
      s_d.value = c.load_val;
    end else if (c.clr) begin
      s_d.value = '0;
    end else if (c.step) begin
      s_d.value = s_q.value + 1'b1;
    end
    s_d.illegal = CHECK && (s_d.value > MAX);
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign c.value = s_q.value;
  assign c.illegal = s_q.illegal;
  assign c.at_max = (s_q.value == MAX);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_step_count;
    c.step && !c.load && !c.clr |=> c.value == $past(c.value) + 1'b1;
  endproperty
  a_step_count: assert property (p_step_count)
    else $error("counter did not advance by one");

  property p_illegal_flag;
    c.illegal == (CHECK && (c.value > MAX));
  endproperty
  a_illegal_flag: assert property (p_illegal_flag)
    else $error("illegal flag disagrees with counter");

endmodule

`default_nettype wire

/* bench/dasq_drive_model.sv */
// behavioural drive: reports its cylinder position on the unit cable
// assumes the bench commands moves with a one-cycle go pulse
`default_nettype none

module dasq_drive_model
  import dasq_pkg::*;
(
  input wire logic clk,           // system clock
  input wire logic go,            // start a move
  input wire logic [7:0] target,  // cylinder to move to
  input wire logic [7:0] delay,   // cycles the move takes
  output logic [7:0] pos          // reported position
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] goal;
  int left;

  initial begin
    pos = 8'h00;
    left = -1;
  end

  // position from drive
  // the move completes only after the requested delay
  always @(posedge clk) begin
    if (go) begin
      goal <= target;
      left <= delay;
    end else if (left == 0) begin
      pos <= goal;
      left <= -1;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end
endmodule

`default_nettype wire

/* bench/testbench.sv */
// self-checking bench for the disk address sequencer
// assumes the drive model is compiled before this file
`include "dasq_defs.svh"
`default_nettype none

module testbench
  import dasq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk, rst_n, ld_a, ld_m, rd_a, cclr, sclr, hclr, yclr, mclr, se, mstep;
  logic wpe, lpe, cme, te, norm, moved, go, s_ill, h_ill, c_ill, wrap, pack, match, seek, done;
  logic [2:0] fn;
  logic [0:17] io, bus;
  logic [7:0] tgt, dly, pos, ca;
  logic [3:0] sa;
  logic [4:0] ha;
  logic [17:0] mp;
  int miscompares, tests_run;

  dasq_top i_dut (.MCLK(mclk), .RESET_N(rst_n), .IO_BUS_IN(io), .LOAD_DISK_ADDRESS_CMD(ld_a),
    .LOAD_MEMORY_POINTER_CMD(ld_m), .READ_DISK_ADDRESS_CMD(rd_a), .CONTROLLER_CLEAR(cclr),
    .SECTOR_COUNTER_CLEAR(sclr), .HEAD_COUNTER_CLEAR(hclr), .CYLINDER_COUNTER_CLEAR(yclr),
    .MEMORY_POINTER_CLEAR(mclr), .SECTOR_END(se), .MAINT_SECTOR_STEP(mstep),
    .WORD_PARITY_ERROR(wpe), .LONGITUDINAL_PARITY_ERROR(lpe), .COMPARE_MISMATCH_ERROR(cme),
    .TIMING_ERROR(te), .NORMAL_MODE(norm), .FUNCTION_CODE(fn), .WORD_MOVED(moved),
    .DRIVE_POSITION_REPORT(pos), .SECTOR_ADDRESS(sa), .HEAD_ADDRESS(ha),
    .CYLINDER_ADDRESS(ca), .MEMORY_POINTER(mp), .SECTOR_ILLEGAL(s_ill),
    .HEAD_ILLEGAL(h_ill), .CYLINDER_ILLEGAL(c_ill), .SECTOR_WRAP_FLAG(wrap),
    .PACK_LIMIT_REACHED(pack), .CYLINDER_MATCH(match), .SEEK_NEEDED(seek),
    .BUS_OUT(bus), .SECTOR_WORDS_DONE(done));

  dasq_drive_model i_drive (.clk(mclk), .go(go), .target(tgt), .delay(dly), .pos(pos));

  // ****************
  // clock and helpers
  // ****************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  task automatic load(input logic [7:0] c, input logic [4:0] h, input logic [3:0] s);
    io = {c, h, 1'b0, s};
    ld_a = 1'b1;
    tick;
    ld_a = 1'b0;
  endtask

  task automatic addr(input logic [7:0] c, input logic [4:0] h, input logic [3:0] s);
    check(ca, c);
    check(ha, h);
    check(sa, s);
  endtask

  // one whole sector end: leading cycle then trailing cycle
  task automatic sec_end;
    se = 1'b1;
    tick;
    se = 1'b0;
    tick;
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_load;
    logic [16:0] tab [4] = '{{8'hCB, 5'h14, 4'hA}, {8'hCA, 5'h13, 4'h9},
                             {8'hFF, 5'h1F, 4'hF}, {8'h00, 5'h00, 4'h0}};
    for (int i = 0; i < 4; i++) begin
      load(tab[i][16:9], tab[i][8:4], tab[i][3:0]);
      addr(tab[i][16:9], tab[i][8:4], tab[i][3:0]);
      check(s_ill, tab[i][3:0] > 4'h9);
      check(h_ill, tab[i][8:4] > 5'h13);
      check(c_ill, tab[i][16:9] > 8'hCA);
      rd_a = 1'b1;
      tick;
      rd_a = 1'b0;
      check(bus, {tab[i][16:4], 1'b0, tab[i][3:0]});
    end
  endtask

  task automatic t_track;
    logic [2:0] f [3] = '{3'h1, 3'h2, 3'h7};
    for (int i = 0; i < 3; i++) begin
      fn = f[i];
      load(8'h05, 5'h03, 4'h8);
      sec_end;
      addr(8'h05, 5'h03, 4'h9);
      se = 1'b1;
      tick;
      check(wrap, 1'b1);
      check(ha, 5'h04);
      se = 1'b0;
      tick;
      addr(8'h05, 5'h04, 4'h0);
      check(wrap, 1'b0);
    end
  endtask

  task automatic t_raw;
    for (int f = 5; f < 7; f++) begin
      fn = 3'(f);
      load(8'h05, 5'h03, 4'h8);
      sec_end;
      addr(8'h05, 5'h04, 4'h9);
      sec_end;
      addr(8'h05, 5'h04, 4'h0);
    end
    // seek function never carries into head
    fn = 3'h4;
    load(8'h05, 5'h03, 4'h9);
    sec_end;
    addr(8'h05, 5'h03, 4'h0);
  endtask

  task automatic t_gate;
    fn = 3'h1;
    for (int k = 0; k < 6; k++) begin
      load(8'h05, 5'h03, 4'h2);
      {wpe, lpe, cme, te} = (k < 4) ? 4'h8 >> k : 4'h0;
      norm = (k != 4);
      sec_end;
      check(sa, (k == 5) ? 4'h3 : 4'h2);
      {wpe, lpe, cme, te} = 4'h0;
      norm = 1'b1;
    end
  endtask

  task automatic t_carry;
    fn = 3'h2;
    load(8'h05, 5'h13, 4'h9);
    sec_end;
    addr(8'h06, 5'h00, 4'h0);
    load(8'hCA, 5'h13, 4'h9);
    sec_end;
    addr(8'h00, 5'h00, 4'h0);
    check(pack, 1'b1);
    io = 18'h3FFFF;
    ld_m = 1'b1;
    tick;
    ld_m = 1'b0;
    cclr = 1'b1;
    tick;
    cclr = 1'b0;
    check(pack, 1'b0);
    check(mp, 18'h00000);
  endtask

  task automatic t_maint_clr;
    load(8'h05, 5'h03, 4'h4);
    mstep = 1'b1;
    tick;
    mstep = 1'b0;
    check(sa, 4'h5);
    load(8'h05, 5'h03, 4'h9);
    mstep = 1'b1;
    tick;
    mstep = 1'b0;
    addr(8'h05, 5'h03, 4'h0);
    load(8'h05, 5'h03, 4'h7);
    {sclr, hclr, yclr} = 3'h7;
    tick;
    {sclr, hclr, yclr} = 3'h0;
    addr(8'h00, 5'h00, 4'h0);
  endtask

  task automatic t_pointer;
    io = 18'h3FFFE;
    ld_m = 1'b1;
    tick;
    ld_m = 1'b0;
    check(mp, 18'h3FFFE);
    moved = 1'b1;
    repeat (3) tick;
    moved = 1'b0;
    check(mp, 18'h00001);
    mclr = 1'b1;
    tick;
    mclr = 1'b0;
    check(mp, 18'h00000);
    load(8'h01, 5'h00, 4'h0);
    se = 1'b1;
    tick;
    se = 1'b0;
    moved = 1'b1;
    repeat (257) tick;
    check(done, 1'b0);
    tick;
    moved = 1'b0;
    check(done, 1'b1);
  endtask

  task automatic t_compare;
    load(8'h40, 5'h00, 4'h0);
    tgt = 8'h40;
    dly = 8'h00;
    go = 1'b1;
    tick;
    go = 1'b0;
    repeat (5) tick;
    check({match, seek}, 2'b10);
    load(8'h41, 5'h00, 4'h0);
    tick;
    check({match, seek}, 2'b01);
    tgt = 8'h41;
    dly = 8'h14;
    go = 1'b1;
    tick;
    go = 1'b0;
    repeat (10) tick;
    check({match, seek}, 2'b01);
    repeat (20) tick;
    check({match, seek}, 2'b10);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    {rst_n, ld_a, ld_m, rd_a, cclr, sclr, hclr, yclr, mclr, se, mstep} = '0;
    {wpe, lpe, cme, te, moved, go} = '0;
    norm = 1'b1;
    fn = 3'h1;
    io = '0;
    tgt = 8'h00;
    dly = 8'h00;
    miscompares = 0;
    tests_run = 0;
    repeat (5) tick;
    rst_n = 1'b1;
    repeat (3) tick;
    t_load;
    t_track;
    t_raw;
    t_gate;
    t_carry;
    t_maint_clr;
    t_pointer;
    t_compare;
    end_of_test;
  end

  // watchdog against a hung run
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    end_of_test;
  end
endmodule

`default_nettype wire
